// [cmd_decode.sv]
// Command byte decoder of the display controller.
// Assumes the access fields are stable while the core samples the result.
`timescale 1ns/1ps
module cmd_decode (
    // Access in, command out
    cmd_if.decoder cif
);
    import lcd_cmd_pkg::*;

    // ==========================================================
    // Decode
    always_comb begin
        cif.kind     = CMD_NONE;
        cif.arg_col  = cif.code[6:0];
        cif.arg_page = cif.code[1:0];
        if (cif.sel) begin
            cif.kind = cif.rd ? CMD_DATA_RD : CMD_DATA_WR;
        end else if (!cif.rd) begin
            if (cif.code == CODE_END) begin
                cif.kind = CMD_END;
            end else if (cif.code == CODE_SOFT_RESET) begin
                cif.kind = CMD_SOFT_RESET;
            end else if (cif.code == CODE_EDIT) begin
                cif.kind = CMD_EDIT;
            end else if (!cif.code[7] && cif.code[6:0] <= COL_LAST) begin
                cif.kind = CMD_SET_COL;
            end else if (cif.code[7:2] == CODE_PAGE_TOP) begin
                cif.kind = CMD_SET_PAGE;
            end
        end
    end

endmodule // cmd_decode

// [cmd_if.sv]
// Carries one host access from the core to the decoder and back.
// Assumes both ends share mclk; the decoder is purely combinational.
`timescale 1ns/1ps
interface cmd_if;
    import lcd_cmd_pkg::*;
    logic [7:0] code;
    logic       sel;
    logic       rd;
    cmd_t       kind;
    logic [6:0] arg_col;
    logic [1:0] arg_page;

    modport decoder (input code, sel, rd, output kind, arg_col, arg_page);
    modport core    (output code, sel, rd, input kind, arg_col, arg_page);
endinterface

// [host_mpu_model.sv]
// Host processor model: APB master and hardware reset pin driver.
// Assumes one bench process calls its tasks; mclk is shared.
`timescale 1ns/1ps
module host_mpu_model (
    // Clock
    input  wire logic        mclk,
    // Reset pin
    output logic             hw_reset_pin_n,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // ==========================================================
    // Idle bus, pin held low at power-up
    initial begin
        hw_reset_pin_n = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end

    // ==========================================================
    // One APB transfer, waits for pready
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic err);
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask

    // ==========================================================
    // Hardware reset pulse
    task automatic pin_pulse(input int n);
        @(posedge mclk);
        hw_reset_pin_n <= 1'b0;
        repeat (n) @(posedge mclk);
        hw_reset_pin_n <= 1'b1;
    endtask
endmodule // host_mpu_model

// [lcd_cmd_end_and_soft_reset.sv]
// Command core of the graphic display controller: edit-mode end,
// soft reset, address registers and status, behind an APB slave.
// Assumes mclk at 250 MHz, srst synchronous, hw reset pin asynchronous.
`timescale 1ns/1ps
module lcd_cmd_end_and_soft_reset (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        hw_reset_pin_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Display data memory port
    output logic             dram_we,
    output logic             dram_re,
    output logic      [6:0]  dram_col,
    output logic      [1:0]  dram_page,
    output logic      [7:0]  dram_wdata,
    // Display timing
    output logic      [4:0]  start_line
);
    import lcd_cmd_pkg::*;

    // ==========================================================
    // State
    logic                 pin_meta;
    logic                 pin_sync;
    logic                 hw_rst;
    logic                 init;
    logic [6:0]           column;
    logic [6:0]           saved_col;
    logic                 edit_mode;
    logic [1:0]           page;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic                 resetting;
    logic                 busy;
    logic                 acc_hit;
    logic                 issue;
    logic                 addr_ok;
    logic [31:0]          next_rdata;
    logic [6:0]           col_inc;

    cmd_if cif ();

    cmd_decode u_decode (
        .cif (cif.decoder)
    );

    // ==========================================================
    // Hardware reset pin synchroniser
    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            pin_meta <= hw_reset_pin_n;
            pin_sync <= pin_meta;
        end
    end

    assign hw_rst = !pin_sync;
    assign init   = srst || hw_rst;

    // ==========================================================
    // Host access
    assign cif.code = pwdata[7:0];
    assign cif.sel  = pwdata[ACC_SEL_BIT];
    assign cif.rd   = pwdata[ACC_RD_BIT];

    assign acc_hit = psel && pwrite && (paddr == OFS_ACCESS);
    assign pready  = !(acc_hit && busy);
    assign issue   = acc_hit && penable && !busy;

    assign col_inc = (column == COL_STOP) ? column : column + 7'h01;

    // ==========================================================
    // Reset execution and busy
    assign resetting = hw_rst || (rst_cnt != '0);
    assign busy      = resetting;

    always_ff @(posedge mclk) begin
        if (init) begin
            rst_cnt <= RST_CNT_LOAD;
        end else if (issue && cif.kind == CMD_SOFT_RESET) begin
            rst_cnt <= RST_CNT_LOAD;
        end else if (rst_cnt != '0) begin
            rst_cnt <= rst_cnt - 4'h1;
        end
    end

    // ==========================================================
    // Column address and editing mode
    always_ff @(posedge mclk) begin
        if (init) begin
            column <= COL_RST;
        end else if (issue) begin
            case (cif.kind)
                CMD_END: begin
                    if (edit_mode) begin
                        column <= saved_col;
                    end
                end
                CMD_SET_COL: begin
                    if (!edit_mode) begin
                        column <= cif.arg_col;
                    end
                end
                CMD_DATA_WR: begin
                    column <= col_inc;
                end
                CMD_DATA_RD: begin
                    if (!edit_mode) begin
                        column <= col_inc;
                    end
                end
                default: begin
                    column <= column;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (init) begin
            edit_mode <= 1'b0;
            saved_col <= COL_RST;
        end else if (issue && cif.kind == CMD_EDIT && !edit_mode) begin
            edit_mode <= 1'b1;
            saved_col <= column;
        end else if (issue && cif.kind == CMD_END) begin
            edit_mode <= 1'b0;
        end
    end

    // ==========================================================
    // Page and start line
    always_ff @(posedge mclk) begin
        if (init) begin
            page <= PAGE_RST;
        end else if (issue && cif.kind == CMD_SOFT_RESET) begin
            page <= PAGE_SOFT;
        end else if (issue && cif.kind == CMD_SET_PAGE) begin
            page <= cif.arg_page;
        end
    end

    always_ff @(posedge mclk) begin
        if (init) begin
            start_line <= START_RST;
        end else if (issue && cif.kind == CMD_SOFT_RESET) begin
            start_line <= START_RST;
        end
    end

    // ==========================================================
    // Display data memory strobes
    always_ff @(posedge mclk) begin
        if (init) begin
            dram_we    <= 1'b0;
            dram_re    <= 1'b0;
            dram_col   <= COL_RST;
            dram_page  <= PAGE_RST;
            dram_wdata <= 8'h00;
        end else begin
            dram_we <= issue && cif.kind == CMD_DATA_WR;
            dram_re <= issue && cif.kind == CMD_DATA_RD;
            if (issue && cif.sel) begin
                dram_col   <= column;
                dram_page  <= page;
                dram_wdata <= cif.code;
            end
        end
    end

    // ==========================================================
    // APB read data and decode
    always_comb begin
        next_rdata = 32'h0000_0000;
        addr_ok    = 1'b1;
        if (paddr == OFS_ACCESS) begin
            next_rdata = 32'h0000_0000;
        end else if (paddr == OFS_STATUS) begin
            next_rdata[ST_BUSY_BIT]  = busy;
            next_rdata[ST_RESET_BIT] = resetting;
            next_rdata[ST_EDIT_BIT]  = edit_mode;
        end else if (paddr == OFS_COLUMN) begin
            next_rdata[6:0] = column;
        end else if (paddr == OFS_PAGE) begin
            next_rdata[1:0] = page;
        end else if (paddr == OFS_START) begin
            next_rdata[4:0] = start_line;
        end else if (paddr == OFS_SAVED) begin
            next_rdata[6:0] = saved_col;
        end else begin
            addr_ok = 1'b0;
        end
    end

    assign pslverr = psel && penable && !addr_ok;

    always_ff @(posedge mclk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_rdata;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_end_code_decode: assert property (
        (!cif.sel && !cif.rd && cif.code == CODE_END) |->
            cif.kind == CMD_END)
        else $error("EE command not decoded as end");

    a_end_restores_col: assert property (
        (issue && cif.kind == CMD_END && edit_mode && !hw_rst) |=>
            (column == $past(saved_col) && !edit_mode))
        else $error("End did not restore saved column");

    a_soft_clears_start: assert property (
        (issue && cif.kind == CMD_SOFT_RESET) |=> start_line == START_RST)
        else $error("Soft reset did not clear start line");

    a_soft_sets_page: assert property (
        (issue && cif.kind == CMD_SOFT_RESET && !hw_rst) |=>
            page == PAGE_SOFT)
        else $error("Soft reset did not load page 3");

    a_soft_no_mem_write: assert property (
        (issue && cif.kind == CMD_SOFT_RESET) |=> !dram_we)
        else $error("Soft reset wrote display memory");

    a_soft_keeps_column: assert property (
        (issue && cif.kind == CMD_SOFT_RESET && !hw_rst) |=>
            (column == $past(column) && edit_mode == $past(edit_mode)))
        else $error("Soft reset disturbed column or edit mode");

    a_edit_no_increment: assert property (
        (issue && cif.kind == CMD_DATA_RD && edit_mode && !hw_rst) |=>
            column == $past(column))
        else $error("Column advanced on read in editing mode");

    a_reset_bit_held: assert property (
        (issue && cif.kind == CMD_SOFT_RESET) |=>
            (resetting && busy) [*8])
        else $error("Reset status bit dropped early");

    a_reset_bit_clears: assert property (
        (issue && cif.kind == CMD_SOFT_RESET && hw_reset_pin_n) ##1
            pin_sync [*8] ##1 pin_sync [*3] |-> !resetting)
        else $error("Reset status bit stuck after reset");

    a_busy_stalls_cmd: assert property (
        (acc_hit && penable && resetting) |-> !pready)
        else $error("Command accepted while reset executing");

    a_edit_saves_col: assert property (
        (issue && cif.kind == CMD_EDIT && !edit_mode && !hw_rst) |=>
            (edit_mode && saved_col == $past(column)))
        else $error("Editing mode entry did not save column");

    a_end_clears_edit: assert property (
        (issue && cif.kind == CMD_END) |=> !edit_mode)
        else $error("End command left editing mode active");

    a_soft_no_mem_read: assert property (
        (issue && cif.kind == CMD_SOFT_RESET) |=> !dram_re)
        else $error("Soft reset read display memory");

    a_hw_reset_inits: assert property (
        hw_rst |=> (column == COL_RST && page == PAGE_RST && !edit_mode))
        else $error("Hardware reset did not initialise registers");

    a_end_idle_keeps: assert property (
        (issue && cif.kind == CMD_END && !edit_mode && !hw_rst) |=>
            column == $past(column))
        else $error("End outside editing mode changed column");

    c_edit_then_end: cover property (
        (issue && cif.kind == CMD_EDIT) ##[1:40]
            (issue && cif.kind == CMD_END));
    c_soft_reset: cover property (issue && cif.kind == CMD_SOFT_RESET);
    c_stalled_access: cover property (acc_hit && penable && !pready);
    c_edit_read: cover property (issue && cif.kind == CMD_DATA_RD
        && edit_mode);
    c_hw_release: cover property ($fell(hw_rst));

endmodule // lcd_cmd_end_and_soft_reset

// [lcd_cmd_end_and_soft_reset_tb_top.sv]
// Self-checking bench of the edit-end and soft reset command core.
// Assumes the host model drives every APB input and the reset pin.
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g));
module lcd_cmd_end_and_soft_reset_tb_top;
    import lcd_cmd_pkg::*;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic        hw_reset_pin_n, psel, penable, pwrite;
    logic        pready, pslverr, dram_we, dram_re, err;
    logic [7:0]  paddr, dram_wdata;
    logic [31:0] pwdata, prdata, q;
    logic [6:0]  dram_col;
    logic [1:0]  dram_page;
    logic [4:0]  start_line;
    int          error_cnt = 0;
    int          checked = 0;
    int          we_cnt = 0;
    int          re_cnt = 0;
    int          w0;

    always #2 mclk = ~mclk;
    always @(negedge mclk) begin
        if (dram_we === 1'b1) we_cnt++;
        if (dram_re === 1'b1) re_cnt++;
    end

    lcd_cmd_end_and_soft_reset lcd_cmd_end_and_soft_reset_inst (
        .mclk(mclk), .srst(srst), .hw_reset_pin_n(hw_reset_pin_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dram_we(dram_we), .dram_re(dram_re),
        .dram_col(dram_col), .dram_page(dram_page),
        .dram_wdata(dram_wdata), .start_line(start_line));
    host_mpu_model host_mpu_model_inst (
        .mclk(mclk), .hw_reset_pin_n(hw_reset_pin_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // ==========================================================
    // Helpers
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cmd(logic [7:0] b, logic s = 0, logic r = 0);
        logic [31:0] d;
        d = 32'(b);
        d[ACC_SEL_BIT] = s;
        d[ACC_RD_BIT] = r;
        host_mpu_model_inst.xfer(1'b1, OFS_ACCESS, d, q, err);
    endtask
    task automatic rd(logic [7:0] a);
        host_mpu_model_inst.xfer(1'b0, a, 32'h0, q, err);
    endtask
    task automatic wait_idle();
        repeat (40) begin
            rd(OFS_STATUS);
            if (q[ST_BUSY_BIT] === 1'b0) break;
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_power();
        host_mpu_model_inst.pin_pulse(4);
        rd(OFS_STATUS);
        `CHK("rst bit", 1'b1, q[ST_RESET_BIT])
        wait_idle();
        `CHK("rst bit idle", 1'b0, q[ST_RESET_BIT])
        rd(OFS_PAGE);
        `CHK("page hw", 2'h0, q[1:0])
    endtask
    task automatic t_soft();
        cmd(8'hb9);
        cmd(8'h10);
        w0 = we_cnt + re_cnt;
        cmd(8'he2);
        rd(OFS_STATUS);
        `CHK("rst bit soft", 1'b1, q[ST_RESET_BIT])
        rd(OFS_COLUMN);
        `CHK("col kept", 7'h10, q[6:0])
        cmd(8'h12);
        rd(OFS_PAGE);
        `CHK("page soft", 2'h3, q[1:0])
        rd(OFS_START);
        `CHK("start reg", 5'h00, q[4:0])
        `CHK("start pin", 5'h00, start_line)
        `CHK("no mem access", w0, we_cnt + re_cnt)
        rd(OFS_COLUMN);
        `CHK("col after", 7'h12, q[6:0])
    endtask
    task automatic t_edit();
        cmd(8'h05);
        cmd(8'he0);
        rd(OFS_STATUS);
        `CHK("edit on", 1'b1, q[ST_EDIT_BIT])
        w0 = re_cnt;
        cmd(8'h00, 1'b1, 1'b1);
        rd(OFS_COLUMN);
        `CHK("col no inc", 7'h05, q[6:0])
        `CHK("rd strobe", w0 + 1, re_cnt)
        rd(OFS_SAVED);
        `CHK("saved col", 7'h05, q[6:0])
        cmd(8'hab, 1'b1, 1'b0);
        @(negedge mclk);
        `CHK("wr data", 8'hab, dram_wdata)
        `CHK("wr col", 7'h05, dram_col)
        `CHK("wr page", 2'h3, dram_page)
        rd(OFS_COLUMN);
        `CHK("col wr inc", 7'h06, q[6:0])
        cmd(8'hee);
        rd(OFS_COLUMN);
        `CHK("col restored", 7'h05, q[6:0])
        rd(OFS_STATUS);
        `CHK("edit off", 1'b0, q[ST_EDIT_BIT])
    endtask
    task automatic t_end_idle();
        cmd(8'h20);
        cmd(8'hee);
        rd(OFS_COLUMN);
        `CHK("col end idle", 7'h20, q[6:0])
        cmd(8'h00, 1'b1, 1'b1);
        rd(OFS_COLUMN);
        `CHK("col rd inc", 7'h21, q[6:0])
        rd(8'h18);
        `CHK("unmapped err", 1'b1, err)
        host_mpu_model_inst.xfer(1'b1, OFS_COLUMN, 32'h7f, q, err);
        rd(OFS_COLUMN);
        `CHK("ro col", 7'h21, q[6:0])
    endtask
    task automatic t_hw();
        cmd(8'hba);
        host_mpu_model_inst.pin_pulse(4);
        wait_idle();
        rd(OFS_PAGE);
        `CHK("page hw again", 2'h0, q[1:0])
        rd(OFS_COLUMN);
        `CHK("col hw", 7'h00, q[6:0])
    endtask

    // ==========================================================
    // Verdict and run
    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        t_power();
        t_soft();
        t_edit();
        t_end_idle();
        t_hw();
        end_of_test();
    end
endmodule // lcd_cmd_end_and_soft_reset_tb_top

// [lcd_cmd_pkg.sv]
// Constants, offsets and command types of the display command decoder.
// Assumes a 250 MHz mclk and an APB register bus with 32-bit data.
package lcd_cmd_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS   = 4;
    localparam int unsigned RST_EXEC_NS     = 40;
    localparam int unsigned RST_EXEC_CYCLES =
        (RST_EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_CNT_W       = 4;
    localparam logic [3:0]  RST_CNT_LOAD    = 4'(RST_EXEC_CYCLES);

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_ACCESS = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_COLUMN = 8'h08;
    localparam logic [7:0] OFS_PAGE   = 8'h0c;
    localparam logic [7:0] OFS_START  = 8'h10;
    localparam logic [7:0] OFS_SAVED  = 8'h14;

    // ==========================================================
    // Field positions
    localparam int unsigned ACC_SEL_BIT  = 8;
    localparam int unsigned ACC_RD_BIT   = 9;
    localparam int unsigned ST_BUSY_BIT  = 7;
    localparam int unsigned ST_RESET_BIT = 4;
    localparam int unsigned ST_EDIT_BIT  = 0;

    // ==========================================================
    // Command codes and address limits
    localparam logic [7:0] CODE_END        = 8'hee;
    localparam logic [7:0] CODE_SOFT_RESET = 8'he2;
    localparam logic [7:0] CODE_EDIT       = 8'he0;
    localparam logic [5:0] CODE_PAGE_TOP   = 6'h2e;
    localparam logic [6:0] COL_LAST        = 7'h4f;
    localparam logic [6:0] COL_STOP        = 7'h50;

    // ==========================================================
    // Reset values
    localparam logic [6:0] COL_RST    = 7'h00;
    localparam logic [1:0] PAGE_RST   = 2'h0;
    localparam logic [4:0] START_RST  = 5'h00;
    localparam logic [1:0] PAGE_SOFT  = 2'h3;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_END,
        CMD_SOFT_RESET,
        CMD_EDIT,
        CMD_SET_COL,
        CMD_SET_PAGE,
        CMD_DATA_WR,
        CMD_DATA_RD
    } cmd_t;

endpackage
